// >>> psp_consts.vh
// Constants for the power-state, PWM and event-pin block
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

// Register indices (word addresses)
`define PSP_REG_CTRL 4'h0
`define PSP_REG_STATUS 4'h1
`define PSP_REG_IRQ_STAT 4'h2
`define PSP_REG_IRQ_MASK 4'h3
`define PSP_REG_PWM_EN 4'h4
`define PSP_REG_CONV 4'h5
`define PSP_REG_EVENT 4'h6
`define PSP_REG_PWM_SEL 4'h7
`define PSP_REG_PWM_DIV 4'h8
`define PSP_REG_PWM_PRE 4'h9
`define PSP_REG_PWM_PER 4'ha
`define PSP_REG_PWM_CMP 4'hb
`define PSP_REG_GPIO_OUT 4'hc
`define PSP_REG_GPIO_OE 4'hd

// Control fields
`define PSP_CTRL_BOOT_DONE 0
`define PSP_CTRL_SLEEP_REQ 1
`define PSP_CTRL_ANA_DIGITAL 2

// Status fields
`define PSP_ST_SLEEP 0
`define PSP_ST_PERMIT 1
`define PSP_ST_PWM_ANY 2
`define PSP_ST_CONV_BUSY 3
`define PSP_ST_EVT_VALID 4
`define PSP_ST_EVT_FULL 5

// Interrupt bits
`define PSP_IRQ_EDGE 0
`define PSP_IRQ_CONV 1
`define PSP_IRQ_DROP 2
`define PSP_IRQ_WAKE 3

// Reset values
`define PSP_CTRL_RESET 3'h0
`define PSP_PWM_DIV_RESET 8'h00
`define PSP_PWM_PRE_RESET 4'h0
`define PSP_PWM_PER_RESET 16'hffff
`define PSP_PWM_CMP_RESET 16'h8000

// Timing
`define PSP_CLK_MHZ 200
`define PSP_PWM_CLK_MHZ 24
`define PSP_CONV_NS 1000
`define PSP_CONV_CYCLES ((`PSP_CONV_NS * `PSP_CLK_MHZ + 999) / 1000)

`endif

// >>> psp_pwm_chan.v
// One PWM channel with divider, prescaler, period and compare
`timescale 1ns/100ps
module psp_pwm_chan
#(
  parameter CW = 16
)
(
  input wire clk,
  input wire rst,
  input wire tick24,
  input wire enable,
  input wire [7:0] divider,
  input wire [3:0] prescale,
  input wire [CW-1:0] period,
  input wire [CW-1:0] compare,
  output reg pwmLevel
);

  reg [7:0] divCount;
  reg [14:0] preCount;
  reg [CW-1:0] count;
  wire [14:0] preLimit;
  wire divTick;
  wire preTick;

  // Prescaler is a power of two, divider an integer
  assign preLimit = (15'h0001 << prescale) - 15'h0001;
  assign divTick = tick24 && (divCount == divider);
  assign preTick = divTick && (preCount >= preLimit);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      divCount <= 8'h00;
      preCount <= 15'h0000;
      count <= {CW{1'b0}};
      pwmLevel <= 1'b0;
    end
    else if (!enable)
    begin
      divCount <= 8'h00;
      preCount <= 15'h0000;
      count <= {CW{1'b0}};
      pwmLevel <= 1'b0;
    end
    else
    begin
      if (tick24)
        divCount <= divTick ? 8'h00 : divCount + 8'h01;
      if (divTick)
        preCount <= preTick ? 15'h0000 : preCount + 15'h0001;
      if (preTick)
        count <= (count >= period) ? {CW{1'b0}} : count + {{(CW-1){1'b0}}, 1'b1};
      pwmLevel <= (count < compare);
    end
  end

endmodule

// >>> psp_event_queue.v
// Edge-event queue toward the host, drops when full unless popped in the same cycle
`timescale 1ns/100ps
module psp_event_queue
#(
  parameter W = 8,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  input wire clk,
  input wire rst,
  input wire pushValid,
  input wire [W-1:0] pushData,
  input wire pop,
  output wire popValid,
  output wire [W-1:0] popData,
  output wire full,
  output wire dropped
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] fill;
  wire doPush;
  wire doPop;

  assign full = (fill == DEPTH[AW:0]);
  assign popValid = (fill != {(AW+1){1'b0}});
  assign popData = mem[rdPtr];
  assign doPop = pop && popValid;
  // Pop frees a slot in the same cycle, so a simultaneous push is kept
  assign doPush = pushValid && (!full || doPop);
  assign dropped = pushValid && !doPush;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr <= (wrPtr == DEPTH - 1) ? {AW{1'b0}} : wrPtr + {{(AW-1){1'b0}}, 1'b1};
      if (doPop)
        rdPtr <= (rdPtr == DEPTH - 1) ? {AW{1'b0}} : rdPtr + {{(AW-1){1'b0}}, 1'b1};
      if (doPush && !doPop)
        fill <= fill + {{AW{1'b0}}, 1'b1};
      else if (doPop && !doPush)
        fill <= fill - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk)
  begin
    if (doPush)
      mem[wrPtr] <= pushData;
  end

endmodule

// >>> psp_pins.v
// Top of the power-state, PWM, conversion and edge-event pin logic
//
// What this block does
// - High sleep-permission input allows but never forces sleep; pulled high by default
// - No sleep state entered while the sleep-permission input is low
// - Power-state output low while active, high in deep sleep or hibernation
// - Power-state output low until boot completes, then high only on sleep request with permission high, no PWM and no conversion
// - UART unavailable while asleep; host checks power-state output first
// - Four PWM channels from 24 MHz ticks, each with own divider, prescaler, period, compare
// - Enabled PWM takes the pin from general I/O; disabling returns it
// - No deep sleep while any PWM channel is enabled
// - Each conversion request made while no conversion is busy does exactly one conversion and returns its result; requests while busy are ignored
// - Conversion request returns the analog pin to high-impedance analog input
// - Each cycle with monitored edges creates one event record in the outgoing queue
// - New edge events are dropped while the queue is full and not popped in the same cycle, setting the drop interrupt bit
`timescale 1ns/100ps
`include "psp_consts.vh"
module psp_pins
#(
  parameter EVT_DEPTH = 4,
  parameter EVT_AW = 2,
  parameter NIN = 4,
  parameter CONV_CYCLES = `PSP_CONV_CYCLES
)
(
  input wire clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  output reg irq,
  input wire sleepPermitIn,
  output reg powerStateOut,
  output reg uartEnable,
  output reg [3:0] pwmOut,
  output reg [3:0] pwmPinOe,
  input wire [NIN-1:0] monitorIn,
  input wire analogInPinIn,
  output reg analogInPinOut,
  output reg analogInPinOe,
  output reg convStart,
  input wire convDone,
  input wire [11:0] convResult
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [1:0] permitSync;
  reg [NIN-1:0] monA;
  reg [NIN-1:0] monB;
  reg [NIN-1:0] monPrev;
  reg anaA;
  reg anaB;
  reg doneA;
  reg doneB;
  reg donePrev;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Reset mirrors the internal pull-up: sleep permitted
      permitSync <= 2'h3;
      monA <= {NIN{1'b0}};
      monB <= {NIN{1'b0}};
      monPrev <= {NIN{1'b0}};
      anaA <= 1'b0;
      anaB <= 1'b0;
      doneA <= 1'b0;
      doneB <= 1'b0;
      donePrev <= 1'b0;
    end
    else
    begin
      permitSync <= {permitSync[0], sleepPermitIn};
      monA <= monitorIn;
      monB <= monA;
      monPrev <= monB;
      anaA <= analogInPinIn;
      anaB <= anaA;
      doneA <= convDone;
      doneB <= doneA;
      donePrev <= doneB;
    end
  end

  wire permit = permitSync[1];
  wire [NIN-1:0] edges = monB ^ monPrev;
  wire doneRise = doneB && !donePrev;

  // ****************************************
  // Registers
  // ****************************************
  reg [2:0] ctrl;
  reg [3:0] irqStat;
  reg [3:0] irqMask;
  reg [3:0] pwmEn;
  reg [1:0] pwmSel;
  reg [7:0] pwmDiv [0:3];
  reg [3:0] pwmPre [0:3];
  reg [15:0] pwmPer [0:3];
  reg [15:0] pwmCmp [0:3];
  reg [3:0] gpioOut;
  reg [3:0] gpioOe;
  reg [11:0] convData;
  reg convBusy;
  reg sleeping;
  integer i;

  wire wrHit = regWr;
  wire convReq = wrHit && (regAddr == `PSP_REG_CONV) && regWrData[0] && !convBusy;
  wire evtPop = regRd && (regAddr == `PSP_REG_EVENT);
  wire pwmAny = |pwmEn;
  wire evtValid;
  wire evtFull;
  wire evtDrop;
  wire [NIN+1:0] evtData;
  wire [NIN-1:0] edgeHit = edges;
  wire edgeAny = |edgeHit;

  // One record per edge cycle: mask of inputs that moved, plus input 0 level
  wire [NIN+1:0] evtRecord = {2'h0, edgeHit} | {monB[0], 1'b0, {NIN{1'b0}}};

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `PSP_CTRL_RESET;
      irqMask <= 4'h0;
      pwmEn <= 4'h0;
      pwmSel <= 2'h0;
      gpioOut <= 4'h0;
      gpioOe <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
        pwmDiv[i] <= `PSP_PWM_DIV_RESET;
        pwmPre[i] <= `PSP_PWM_PRE_RESET;
        pwmPer[i] <= `PSP_PWM_PER_RESET;
        pwmCmp[i] <= `PSP_PWM_CMP_RESET;
      end
    end
    else
    begin
      if (wrHit)
      begin
        case (regAddr)
          `PSP_REG_CTRL: ctrl <= regWrData[2:0];
          `PSP_REG_IRQ_MASK: irqMask <= regWrData[3:0];
          `PSP_REG_PWM_EN: pwmEn <= regWrData[3:0];
          `PSP_REG_PWM_SEL: pwmSel <= regWrData[1:0];
          `PSP_REG_PWM_DIV: pwmDiv[pwmSel] <= regWrData[7:0];
          `PSP_REG_PWM_PRE: pwmPre[pwmSel] <= regWrData[3:0];
          `PSP_REG_PWM_PER: pwmPer[pwmSel] <= regWrData[15:0];
          `PSP_REG_PWM_CMP: pwmCmp[pwmSel] <= regWrData[15:0];
          `PSP_REG_GPIO_OUT: gpioOut <= regWrData[3:0];
          `PSP_REG_GPIO_OE: gpioOe <= regWrData[3:0];
          default: ;
        endcase
      end
      if (convReq)
        ctrl[`PSP_CTRL_ANA_DIGITAL] <= 1'b0;
    end
  end

  // ****************************************
  // 24 MHz tick from 200 MHz by fractional accumulator
  // ****************************************
  reg [7:0] fracAcc;
  reg tick24;
  wire [8:0] fracSum = {1'b0, fracAcc} + 9'd`PSP_PWM_CLK_MHZ;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fracAcc <= 8'h00;
      tick24 <= 1'b0;
    end
    else if (fracSum >= 9'd`PSP_CLK_MHZ)
    begin
      fracAcc <= fracSum[7:0] - 8'd`PSP_CLK_MHZ;
      tick24 <= 1'b1;
    end
    else
    begin
      fracAcc <= fracSum[7:0];
      tick24 <= 1'b0;
    end
  end

  // ****************************************
  // PWM channels and pin muxing
  // ****************************************
  wire [3:0] pwmLevel;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      psp_pwm_chan #(.CW(16)) u_chan
      (
        .clk(clk),
        .rst(rst),
        .tick24(tick24),
        .enable(pwmEn[g]),
        .divider(pwmDiv[g]),
        .prescale(pwmPre[g]),
        .period(pwmPer[g]),
        .compare(pwmCmp[g]),
        .pwmLevel(pwmLevel[g])
      );
    end
  endgenerate

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwmOut <= 4'h0;
      pwmPinOe <= 4'h0;
    end
    else
    begin
      pwmOut <= (pwmEn & pwmLevel) | (~pwmEn & gpioOut);
      pwmPinOe <= pwmEn | gpioOe;
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  // Sleep needs boot done, software request, permission high, no PWM running and no conversion busy
  wire sleepOk = ctrl[`PSP_CTRL_BOOT_DONE] && ctrl[`PSP_CTRL_SLEEP_REQ] && permit && !pwmAny && !convBusy;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sleeping <= 1'b0;
      powerStateOut <= 1'b0;
      uartEnable <= 1'b1;
    end
    else
    begin
      sleeping <= sleepOk;
      powerStateOut <= sleepOk;
      uartEnable <= !sleepOk;
    end
  end

  // ****************************************
  // Single conversion
  // ****************************************
  reg [15:0] convTimer;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      convBusy <= 1'b0;
      convStart <= 1'b0;
      convData <= 12'h000;
      convTimer <= 16'h0000;
    end
    else
    begin
      convStart <= convReq;
      if (convReq)
      begin
        convBusy <= 1'b1;
        convTimer <= CONV_CYCLES[15:0];
      end
      else if (convBusy && (doneRise || convTimer == 16'h0001))
      begin
        convBusy <= 1'b0;
        convData <= convResult;
      end
      else if (convBusy && convTimer != 16'h0000)
        convTimer <= convTimer - 16'h0001;
    end
  end

  // Analog pin: driven only when software picked digital mode and no conversion runs
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      analogInPinOut <= 1'b0;
      analogInPinOe <= 1'b0;
    end
    else
    begin
      analogInPinOut <= gpioOut[0];
      analogInPinOe <= ctrl[`PSP_CTRL_ANA_DIGITAL] && !convReq && !convBusy;
    end
  end

  // ****************************************
  // Edge events
  // ****************************************
  psp_event_queue #(.W(NIN+2), .DEPTH(EVT_DEPTH), .AW(EVT_AW)) u_queue
  (
    .clk(clk),
    .rst(rst),
    .pushValid(edgeAny),
    .pushData(evtRecord),
    .pop(evtPop),
    .popValid(evtValid),
    .popData(evtData),
    .full(evtFull),
    .dropped(evtDrop)
  );

  // ****************************************
  // Interrupts, set wins over write-one-to-clear
  // ****************************************
  wire [3:0] irqSet = {sleeping && !sleepOk, evtDrop, convBusy && !convReq && (doneRise || convTimer == 16'h0001), edgeAny};
  wire [3:0] irqClr = (wrHit && regAddr == `PSP_REG_IRQ_STAT) ? regWrData[3:0] : 4'h0;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqStat <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      irqStat <= (irqStat & ~irqClr) | irqSet;
      irq <= |(((irqStat & ~irqClr) | irqSet) & irqMask);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h00000000;
    else if (regRd)
    begin
      case (regAddr)
        `PSP_REG_CTRL: regRdData <= {29'h0, ctrl};
        `PSP_REG_STATUS: regRdData <= {26'h0, evtFull, evtValid, convBusy, pwmAny, permit, sleeping};
        `PSP_REG_IRQ_STAT: regRdData <= {28'h0, irqStat};
        `PSP_REG_IRQ_MASK: regRdData <= {28'h0, irqMask};
        `PSP_REG_PWM_EN: regRdData <= {28'h0, pwmEn};
        `PSP_REG_CONV: regRdData <= {convBusy, 19'h0, convData};
        `PSP_REG_EVENT: regRdData <= {evtValid, {(31-NIN-2){1'b0}}, evtData};
        `PSP_REG_PWM_SEL: regRdData <= {30'h0, pwmSel};
        `PSP_REG_PWM_DIV: regRdData <= {24'h0, pwmDiv[pwmSel]};
        `PSP_REG_PWM_PRE: regRdData <= {28'h0, pwmPre[pwmSel]};
        `PSP_REG_PWM_PER: regRdData <= {16'h0, pwmPer[pwmSel]};
        `PSP_REG_PWM_CMP: regRdData <= {16'h0, pwmCmp[pwmSel]};
        `PSP_REG_GPIO_OUT: regRdData <= {27'h0, anaB, gpioOut};
        `PSP_REG_GPIO_OE: regRdData <= {28'h0, gpioOe};
        default: regRdData <= 32'h00000000;
      endcase
    end
    else
      regRdData <= 32'h00000000;
  end

endmodule

// >>> psp_pins_props.sv
// Concurrent checks on the pin-level ports of the power-state block
`timescale 1ns/100ps
module psp_pins_props
(
  input wire clk,
  input wire rst,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdData,
  input wire irq,
  input wire sleepPermitIn,
  input wire powerStateOut,
  input wire uartEnable,
  input wire [3:0] pwmPinOe,
  input wire analogInPinOe,
  input wire convStart
);
  // ****************************************
  // Pin relations
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire pwmWr = regWr && regAddr == 4'h4;
  wire convWr = regWr && regAddr == 4'h5 && regWrData[0];
  wire [3:0] wrLow = regWrData[3:0];
  a_uart_follows_state: assert property (uartEnable != powerStateOut)
    else $error("uart enable disagrees with power state");
  // Five samples cover the two-stage synchroniser plus the output register
  a_permit_holds_awake: assert property (!sleepPermitIn [*5] |-> !powerStateOut)
    else $error("asleep while sleep permission is low");
  a_pwm_blocks_sleep: assert property (pwmWr && wrLow != 4'h0 |-> ##3 !powerStateOut)
    else $error("asleep with a pwm channel enabled");
  a_pwm_takes_pin: assert property (pwmWr |-> ##2 (pwmPinOe & $past(wrLow, 2)) == $past(wrLow, 2))
    else $error("enabled pwm channel not driving its pin");
  a_conv_single_pulse: assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  a_conv_has_cause: assert property (convStart |-> $past(convWr))
    else $error("conversion start without a request");
  a_conv_pin_analog: assert property (convWr |-> ##2 !analogInPinOe [*4])
    else $error("analog pin still driven after conversion request");
  a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data not zero outside read answer cycle");
  c_sleep_entered: cover property ($rose(powerStateOut));
  c_conv_started: cover property (convStart);
  c_irq_raised: cover property ($rose(irq));
endmodule

// >>> psp_conv_model.sv
// Converter stand-in answering conversion starts after a set delay
`timescale 1ns/100ps
module psp_conv_model
(
  input wire clk,
  input wire rst,
  input wire convStart,
  input wire [7:0] convDelay,
  input wire [11:0] convValue,
  output reg convDone,
  output reg [11:0] convResult
);
  reg [7:0] waitCnt;
  reg [3:0] holdCnt;
  // Result is only held while done is high; it flips afterwards so a late sample shows
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      waitCnt <= 8'h00;
      holdCnt <= 4'h0;
      convDone <= 1'b0;
      convResult <= 12'h000;
    end
    else if (convStart)
      waitCnt <= convDelay;
    else if (waitCnt != 8'h00)
    begin
      waitCnt <= waitCnt - 8'h01;
      if (waitCnt == 8'h01)
      begin
        convDone <= 1'b1;
        convResult <= convValue;
        holdCnt <= 4'h8;
      end
    end
    else if (holdCnt != 4'h0)
    begin
      holdCnt <= holdCnt - 4'h1;
      if (holdCnt == 4'h1)
      begin
        convDone <= 1'b0;
        convResult <= ~convResult;
      end
    end
  end
endmodule

// >>> psp_pins_tb_top.sv
// Self-checking bench for the power-state, pwm, conversion and event pins
`timescale 1ns/100ps
module psp_pins_tb_top;
  reg clk, rst, regWr, regRd, sleepPermitIn, analogInPinIn;
  reg [3:0] regAddr, monitorIn;
  reg [31:0] regWrData, v;
  reg [7:0] convDelay;
  reg [11:0] convValue;
  wire [31:0] regRdData;
  wire irq, powerStateOut, uartEnable, analogInPinOut, analogInPinOe, convStart, convDone;
  wire [3:0] pwmOut, pwmPinOe;
  wire [11:0] convResult;
  integer errors, comparisons, starts, i, hi;
  psp_pins #(.CONV_CYCLES(40)) psp_pins_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .sleepPermitIn(sleepPermitIn),
    .powerStateOut(powerStateOut), .uartEnable(uartEnable), .pwmOut(pwmOut), .pwmPinOe(pwmPinOe),
    .monitorIn(monitorIn), .analogInPinIn(analogInPinIn), .analogInPinOut(analogInPinOut),
    .analogInPinOe(analogInPinOe), .convStart(convStart), .convDone(convDone), .convResult(convResult));
  psp_conv_model psp_conv_model_i (.clk(clk), .rst(rst), .convStart(convStart), .convDelay(convDelay),
    .convValue(convValue), .convDone(convDone), .convResult(convResult));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
    if (convStart)
      starts <= starts + 1;
  // ****************************************
  // Access tasks
  // ****************************************
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdData;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #50000;
    errors = errors + 1;
    conclude;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    errors = 0;
    comparisons = 0;
    starts = 0;
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    sleepPermitIn = 1'b1;
    analogInPinIn = 1'b0;
    monitorIn = 4'h0;
    convDelay = 8'h02;
    convValue = 12'habc;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(6);
    chk("powerStateOut", powerStateOut, 0);
    chk("uartEnable", uartEnable, 1);
    rd(4'h1);
    chk("status", v, 32'h2);
    wr(4'h0, 32'h3);
    cyc(6);
    chk("sleepAfterBoot", powerStateOut, 1);
    chk("uartAsleep", uartEnable, 0);
    @(posedge clk);
    sleepPermitIn <= 1'b0;
    cyc(6);
    chk("heldAwake", powerStateOut, 0);
    chk("irqMasked", irq, 0);
    wr(4'h3, 32'h8);
    cyc(2);
    chk("irqWake", irq, 1);
    rd(4'h2);
    chk("irqStat", v, 32'h8);
    wr(4'h2, 32'h8);
    cyc(2);
    chk("irqCleared", irq, 0);
    @(posedge clk);
    sleepPermitIn <= 1'b1;
    cyc(6);
    chk("sleepAgain", powerStateOut, 1);
    wr(4'h8, 32'h0);
    wr(4'h9, 32'h0);
    wr(4'ha, 32'h3);
    wr(4'hb, 32'h2);
    wr(4'h4, 32'h5);
    cyc(4);
    chk("pwmAwake", powerStateOut, 0);
    chk("pwmOe", pwmPinOe, 4'h5);
    hi = 0;
    for (i = 0; i < 300; i = i + 1)
    begin
      cyc(1);
      hi = hi + (pwmOut[0] === 1'b1);
    end
    // Compare 2 of period 0..3 gives half duty; tick jitter allows a wide band
    chk("pwmDuty", hi > 100 && hi < 200, 1);
    wr(4'h4, 32'h0);
    cyc(4);
    chk("pwmOeOff", pwmPinOe, 4'h0);
    chk("pwmSleep", powerStateOut, 1);
    // With pwm off the pins fall back to plain outputs
    @(posedge clk);
    analogInPinIn <= 1'b1;
    wr(4'hc, 32'h5);
    wr(4'hd, 32'h3);
    cyc(3);
    chk("gpioOut", pwmOut, 4'h5);
    chk("gpioOe", pwmPinOe, 4'h3);
    chk("anaOut", analogInPinOut, 1);
    rd(4'hc);
    chk("anaIn", v, 32'h15);
    for (i = 0; i < 2; i = i + 1)
    begin
      // Digital mode again each round, so every request must undo it
      wr(4'h0, 32'h7);
      cyc(3);
      chk("anaDigital", analogInPinOe, 1);
      @(posedge clk);
      convDelay <= i ? 8'h14 : 8'h02;
      convValue <= i ? 12'h123 : 12'habc;
      wr(4'h5, 32'h1);
      wr(4'h5, 32'h1);
      cyc(1);
      chk("anaHighZ", analogInPinOe, 0);
      cyc(40);
      rd(4'h5);
      chk("convResult", v, i ? 32'h123 : 32'habc);
    end
    chk("convStarts", starts, 2);
    wr(4'h2, 32'hf);
    for (i = 0; i < 6; i = i + 1)
    begin
      @(posedge clk);
      monitorIn <= i < 4 ? monitorIn | (4'h1 << i) : monitorIn ^ 4'h1;
      cyc(4);
    end
    rd(4'h2);
    chk("edgeDropStat", v, 32'h5);
    for (i = 0; i < 4; i = i + 1)
    begin
      rd(4'h6);
      chk("event", v, 32'h80000020 | (32'h1 << i));
    end
    rd(4'h6);
    chk("queueEmpty", v[31], 0);
    rd(4'hf);
    chk("unmapped", v, 32'h0);
    conclude;
  end
endmodule
bind psp_pins psp_pins_props psp_pins_props_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .sleepPermitIn(sleepPermitIn),
  .powerStateOut(powerStateOut), .uartEnable(uartEnable), .pwmPinOe(pwmPinOe),
  .analogInPinOe(analogInPinOe), .convStart(convStart));
